// [core/swg_top.sv]
// Overview of operation
// [RL1] shape selects a constant dc level or a periodic waveform
// [RL2] dc shape drives the programmed amplitude straight to the output
// [RL3] periodic shapes use amplitude as peak swing about the offset
// [RL4] sine amplitude may be given as rms, converted to peak internally
// [RL5] offset is added to every periodic sample
// [RL6] dc shape ignores offset and clears the stored offset
// [RL7] duty is 0 to 1.0 and only affects square and triangle
// [RL8] one waveform cycle lasts the reciprocal of the frequency
// [RL9] square switches between offset plus and minus amplitude
// [RL10] square stays high for the duty fraction of each cycle
// [RL11] square duty supports 0.001 through 0.999
// [RL12] square duty of 0 or 1 gives a constant level
// [RL13] triangle ramps linearly low to high then back down
// [RL14] triangle rises for the duty fraction, falls for the rest
// [RL15] triangle duty settable 0 to 1 in 0.1 percent steps
// [RL16] triangle duty 0 or 1 yields a sawtooth
// [RL17] disabled output applies no excitation
// [RL18] phase accumulator steps once per sample by frequency word
// [RL19] new settings take effect only at a cycle boundary; the code also swaps them in at once while disabled or in dc
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// sample fifo
// ----------------------------------------
module swg_fifo #(
   parameter int W = 16,
   parameter int D = 4
) (
   input  wire logic         i_clk,
   input  wire logic         i_reset_n,
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_out_valid,
   input  wire logic         i_out_ready,
   output logic [W-1:0]      o_out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0]  wr_ff;
   logic [AW:0]  rd_ff;
   logic         full;
   logic         empty;
   logic         push;
   logic         pop;
   assign full  = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
   assign empty = (wr_ff == rd_ff);
   assign push  = i_in_valid && !full;
   assign pop   = i_out_ready && !empty;
   assign o_in_ready  = !full;
   assign o_out_valid = !empty;
   assign o_out_data  = mem[rd_ff[AW-1:0]];
   always_ff @(posedge i_clk)
   begin
      if (push)
      begin
         mem[wr_ff[AW-1:0]] <= i_in_data;
      end
   end
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         wr_ff <= '0;
         rd_ff <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ff <= wr_ff + 1'b1;
         end
         if (pop)
         begin
            rd_ff <= rd_ff + 1'b1;
         end
      end
   end
endmodule
// ----------------------------------------
// waveform generator top
// ----------------------------------------
module swg_top #(
   parameter int FIFO_DEPTH = 4
) (
   input  wire logic        I_CLK,
   input  wire logic        I_RESET_N,
   input  wire logic        I_WB_CYC,
   input  wire logic        I_WB_STB,
   input  wire logic        I_WB_WE,
   input  wire logic [7:0]  I_WB_ADR,
   input  wire logic [3:0]  I_WB_SEL,
   input  wire logic [31:0] I_WB_DAT,
   output logic [31:0]      O_WB_DAT,
   output logic             O_WB_ACK,
   output logic [15:0]      O_SAMPLE_DATA,
   output logic             O_SAMPLE_VALID,
   input  wire logic        I_SAMPLE_READY,
   output logic             O_OUT_EN
);
   function automatic logic [31:0] bmerge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++)
      begin
         if (s[i])
         begin
            r[i*8 +: 8] = n[i*8 +: 8];
         end
      end
      return r;
   endfunction
   // ----------------------------------------
   // wishbone slave
   // ----------------------------------------
   logic        req;
   logic        wr;
   logic [31:0] ctrl_w;
   logic [31:0] amp_w;
   logic [31:0] offs_w;
   logic [31:0] freq_w;
   logic [31:0] duty_w;
   logic        en_ff;
   logic        rms_ff;
   swg_pkg::swg_shape_t shape_ff;
   logic [15:0] amp_ff;
   logic [15:0] offs_ff;
   logic [31:0] step_ff;
   logic [9:0]  duty_ff;
   logic        pend_ff;
   logic [15:0] samp_ff;
   logic        fifo_full;
   assign req    = I_WB_CYC && I_WB_STB && !O_WB_ACK;
   assign wr     = req && I_WB_WE;
   assign ctrl_w = bmerge({28'h0, rms_ff, shape_ff, en_ff}, I_WB_DAT, I_WB_SEL);
   assign amp_w  = bmerge({16'h0, amp_ff}, I_WB_DAT, I_WB_SEL);
   assign offs_w = bmerge({16'h0, offs_ff}, I_WB_DAT, I_WB_SEL);
   assign freq_w = bmerge(step_ff, I_WB_DAT, I_WB_SEL);
   assign duty_w = bmerge({22'h0, duty_ff}, I_WB_DAT, I_WB_SEL);
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         O_WB_ACK <= 1'b0;
         O_WB_DAT <= 32'h0;
      end
      else
      begin
         O_WB_ACK <= req;
         if (req && !I_WB_WE)
         begin
            unique case (I_WB_ADR)
               swg_pkg::A_CTRL: O_WB_DAT <= {28'h0, rms_ff, shape_ff, en_ff};
               swg_pkg::A_AMP:  O_WB_DAT <= {16'h0, amp_ff};
               swg_pkg::A_OFFS: O_WB_DAT <= {16'h0, offs_ff};
               swg_pkg::A_FREQ: O_WB_DAT <= step_ff;
               swg_pkg::A_DUTY: O_WB_DAT <= {22'h0, duty_ff};
               swg_pkg::A_STAT: O_WB_DAT <= {29'h0, fifo_full, pend_ff, en_ff};
               swg_pkg::A_SAMP: O_WB_DAT <= {16'h0, samp_ff};
               default:         O_WB_DAT <= 32'h0;
            endcase
         end
      end
   end
   // ----------------------------------------
   // setting registers
   // ----------------------------------------
   // [RL1] shape and enable control
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         en_ff    <= 1'b0;
         shape_ff <= swg_pkg::SWG_DC;
         rms_ff   <= 1'b0;
      end
      else if (wr && I_WB_ADR == swg_pkg::A_CTRL)
      begin
         en_ff    <= ctrl_w[swg_pkg::CTRL_EN];
         shape_ff <= swg_pkg::swg_shape_t'(ctrl_w[swg_pkg::CTRL_SHP +: 2]);
         rms_ff   <= ctrl_w[swg_pkg::CTRL_RMS];
      end
   end
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         amp_ff  <= swg_pkg::AMP_RST;
         step_ff <= swg_pkg::STEP_RST;
      end
      else
      begin
         if (wr && I_WB_ADR == swg_pkg::A_AMP)
         begin
            amp_ff <= amp_w[15:0];
         end
         if (wr && I_WB_ADR == swg_pkg::A_FREQ)
         begin
            step_ff <= freq_w;
         end
      end
   end
   // [RL6] dc forces stored offset to zero
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         offs_ff <= 16'h0;
      end
      else if (shape_ff == swg_pkg::SWG_DC)
      begin
         offs_ff <= 16'h0;
      end
      else if (wr && I_WB_ADR == swg_pkg::A_OFFS)
      begin
         offs_ff <= offs_w[15:0];
      end
   end
   // [RL15] duty in 0.1 percent units, clamped to 1.0
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         duty_ff <= swg_pkg::DUTY_RST;
      end
      else if (wr && I_WB_ADR == swg_pkg::A_DUTY)
      begin
         duty_ff <= (duty_w > {22'h0, swg_pkg::DUTY_FULL}) ? swg_pkg::DUTY_FULL
                                                            : duty_w[9:0];
      end
   end
   // ----------------------------------------
   // active settings, swapped at a cycle boundary, or at once while stopped or in dc
   // ----------------------------------------
   swg_pkg::swg_cfg_t cfg_ff;
   swg_pkg::swg_cfg_t nxt_cfg;
   logic [31:0] phase_ff;
   logic [32:0] ph_sum;
   logic        push;
   logic        wrap;
   logic        load;
   logic [32:0] amp_rms;
   logic [26:0] duty_q16;
   always_comb
   begin
      amp_rms  = {17'h0, amp_ff} * {16'h0, swg_pkg::SQRT2_Q16};
      // [RL7] duty only feeds the square and triangle threshold
      duty_q16 = 27'({duty_ff, 16'h0} / 26'd1000);
      nxt_cfg.shape = shape_ff;
      nxt_cfg.offs  = offs_ff;
      nxt_cfg.step  = step_ff;
      // [RL10] duty fraction as phase threshold
      // [RL11] 0.1 percent steps reach 0.001 and 0.999
      nxt_cfg.thr   = duty_q16[16:0];
      // [RL4] rms to peak conversion for sine
      if (rms_ff && shape_ff == swg_pkg::SWG_SINE)
      begin
         nxt_cfg.amp = (amp_rms[32:16] > 17'h7fff) ? 16'h7fff : amp_rms[31:16];
      end
      else
      begin
         nxt_cfg.amp = amp_ff;
      end
      // slopes precomputed here so the sample path needs no divider
      // [RL16] zero slope at duty ends gives a sawtooth
      nxt_cfg.k_up = (duty_ff == 10'h0) ? 27'h0 : swg_pkg::K_SCALE / {17'h0, duty_ff};
      nxt_cfg.k_dn = (duty_ff == swg_pkg::DUTY_FULL) ? 27'h0 :
                     swg_pkg::K_SCALE / {17'h0, swg_pkg::DUTY_FULL - duty_ff};
   end
   // [RL8] carry out marks one full period
   assign ph_sum = {1'b0, phase_ff} + {1'b0, cfg_ff.step};
   assign wrap   = push && ph_sum[32];
   // [RL19] swap only on wrap, while stopped, or in dc
   assign load   = pend_ff && (!en_ff || wrap || cfg_ff.shape == swg_pkg::SWG_DC);
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         cfg_ff <= '0;
      end
      else if (load)
      begin
         cfg_ff <= nxt_cfg;
      end
   end
   // write in the load cycle keeps the flag set
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         pend_ff <= 1'b1;
      end
      else
      begin
         pend_ff <= (wr && I_WB_ADR != swg_pkg::A_STAT) || (pend_ff && !load);
      end
   end
   // [RL18] phase steps once per pushed sample
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         phase_ff <= 32'h0;
      end
      else if (!en_ff)
      begin
         phase_ff <= 32'h0;
      end
      else if (push)
      begin
         phase_ff <= ph_sum[31:0];
      end
   end
   // ----------------------------------------
   // sample computation
   // ----------------------------------------
   logic [15:0] ph16;
   logic        rising;
   logic [42:0] pu;
   logic [42:0] pd;
   logic [16:0] ratio;
   logic [33:0] span;
   logic [33:0] uu;
   logic [16:0] y;
   logic [33:0] yy;
   logic [33:0] mix;
   logic [32:0] sv;
   logic signed [18:0] wave;
   logic signed [18:0] tot;
   logic [15:0] samp;
   always_comb
   begin
      ph16 = phase_ff[31:16];
      // [RL14] rising part spans the duty fraction
      rising = {1'b0, ph16} < cfg_ff.thr;
      pu = {27'h0, ph16} * {16'h0, cfg_ff.k_up};
      pd = {27'h0, 16'(ph16 - cfg_ff.thr[15:0])} * {16'h0, cfg_ff.k_dn};
      ratio = rising ? ((pu[42:16] > 27'h10000) ? swg_pkg::ONE_Q16 : pu[32:16])
                     : ((pd[42:16] > 27'h10000) ? swg_pkg::ONE_Q16 : pd[32:16]);
      span = {17'h0, cfg_ff.amp, 1'b0} * {17'h0, ratio} >> 16;
      // parabolic sine with second order correction
      uu  = {17'h0, 1'b0, phase_ff[30:15]} * {17'h0, swg_pkg::ONE_Q16 - {1'b0, phase_ff[30:15]}};
      y   = uu[30:14];
      yy  = {17'h0, y} * {17'h0, y};
      mix = {17'h0, 1'b0, swg_pkg::SIN_C1} * {17'h0, y}
          + {17'h0, 1'b0, swg_pkg::SIN_C2} * {17'h0, yy[32:16]};
      // [RL3] amplitude scales the peak
      sv  = {17'h0, cfg_ff.amp} * {16'h0, mix[32:16]};
      unique case (cfg_ff.shape)
         // [RL2] dc level is the amplitude itself
         swg_pkg::SWG_DC:     wave = 19'(signed'(cfg_ff.amp));
         swg_pkg::SWG_SINE:   wave = phase_ff[31] ? -19'(sv[32:16]) : 19'(sv[32:16]);
         // [RL12] empty or full threshold holds one level
         // [RL9] square levels at plus and minus amplitude
         swg_pkg::SWG_SQUARE: wave = rising ? 19'(cfg_ff.amp) : -19'(cfg_ff.amp);
         // [RL13] linear ramps between the two peaks
         swg_pkg::SWG_TRI:    wave = rising ? 19'(span[17:0]) - 19'(cfg_ff.amp)
                                            : 19'(cfg_ff.amp) - 19'(span[17:0]);
      endcase
      // [RL5] offset added to every periodic sample
      tot = (cfg_ff.shape == swg_pkg::SWG_DC) ? wave : wave + 19'(cfg_ff.offs);
      if (!en_ff)
      begin
         samp = 16'h0;
      end
      else if (tot > 19'sh07fff)
      begin
         samp = 16'h7fff;
      end
      else if (tot < -19'sh08000)
      begin
         samp = 16'h8000;
      end
      else
      begin
         samp = tot[15:0];
      end
   end
   // ----------------------------------------
   // buffer and output stage
   // ----------------------------------------
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic [15:0] fifo_out_data;
   logic        drain;
   assign push      = fifo_in_ready;
   assign fifo_full = !fifo_in_ready;
   assign drain     = !O_SAMPLE_VALID || I_SAMPLE_READY;
   swg_fifo #(
      .W (16),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .i_clk       (I_CLK),
      .i_reset_n   (I_RESET_N),
      .i_in_valid  (1'b1),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (samp),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (drain),
      .o_out_data  (fifo_out_data)
   );
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         O_SAMPLE_VALID <= 1'b0;
         O_SAMPLE_DATA  <= 16'h0;
         samp_ff        <= 16'h0;
      end
      else if (drain)
      begin
         O_SAMPLE_VALID <= fifo_out_valid;
         O_SAMPLE_DATA  <= fifo_out_data;
         if (fifo_out_valid)
         begin
            samp_ff <= fifo_out_data;
         end
      end
   end
   // [RL17] excitation connected only when enabled
   always_ff @(posedge I_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         O_OUT_EN <= 1'b0;
      end
      else
      begin
         O_OUT_EN <= en_ff;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RESET_N);
   wb_ack_a: assert property (req |=> O_WB_ACK ##1 !O_WB_ACK) // wishbone handshake, our own choice
      else $error("wishbone ack not single cycle");
   dc_level_a: assert property (en_ff && cfg_ff.shape == swg_pkg::SWG_DC && push // [RL2]
      && !cfg_ff.amp[15] |-> samp == cfg_ff.amp)
      else $error("dc sample differs from amplitude");
   dc_offs_a: assert property (shape_ff == swg_pkg::SWG_DC |=> offs_ff == 16'h0) // [RL6]
      else $error("offset not cleared in dc");
   sq_level_a: assert property (en_ff && cfg_ff.shape == swg_pkg::SWG_SQUARE // [RL9]
      |-> wave == (rising ? 19'(cfg_ff.amp) : -19'(cfg_ff.amp)))
      else $error("square level wrong");
   sq_duty0_a: assert property (cfg_ff.shape == swg_pkg::SWG_SQUARE // [RL12]
      && cfg_ff.thr == 17'h0 |-> !rising)
      else $error("duty zero square toggles");
   duty_max_a: assert property (duty_ff <= swg_pkg::DUTY_FULL) // [RL15]
      else $error("duty above full scale");
   off_zero_a: assert property (!en_ff |-> samp == 16'h0 ##1 !O_OUT_EN) // [RL17]
      else $error("excitation while disabled");
   phase_step_a: assert property (en_ff && push ##1 en_ff // [RL18]
      |-> phase_ff == $past(phase_ff) + $past(cfg_ff.step))
      else $error("phase did not advance by step");
   cfg_hold_a: assert property (en_ff && !wrap && cfg_ff.shape != swg_pkg::SWG_DC // [RL19]
      |=> cfg_ff == $past(cfg_ff))
      else $error("settings changed mid cycle");
   tri_peak_a: assert property (en_ff && cfg_ff.shape == swg_pkg::SWG_TRI // [RL13]
      |-> wave <= $signed({3'b000, cfg_ff.amp}) && wave >= -$signed({3'b000, cfg_ff.amp}))
      else $error("triangle outside peaks");
   wrap_c: cover property (en_ff && wrap);
   stall_c: cover property (fifo_full ##1 fifo_full);
   swap_c: cover property (pend_ff && load ##1 en_ff);
endmodule
`default_nettype wire

// [core/swg_pkg.sv]
`default_nettype none
package swg_pkg;
   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_AMP  = 8'h04;
   localparam logic [7:0] A_OFFS = 8'h08;
   localparam logic [7:0] A_FREQ = 8'h0c;
   localparam logic [7:0] A_DUTY = 8'h10;
   localparam logic [7:0] A_STAT = 8'h14;
   localparam logic [7:0] A_SAMP = 8'h18;
   localparam int CTRL_EN  = 0;
   localparam int CTRL_SHP = 1;
   localparam int CTRL_RMS = 3;
   // ----------------------------------------
   // reset values and arithmetic constants
   // ----------------------------------------
   localparam logic [15:0] AMP_RST   = 16'h0000;
   localparam logic [31:0] STEP_RST  = 32'h0000_0000;
   localparam logic [9:0]  DUTY_FULL = 10'h3e8;
   localparam logic [9:0]  DUTY_RST  = 10'h1f4;
   localparam logic [16:0] ONE_Q16   = 17'h10000;
   localparam logic [16:0] SQRT2_Q16 = 17'h16a0a;
   localparam logic [15:0] SIN_C1    = 16'hc666;
   localparam logic [15:0] SIN_C2    = 16'h399a;
   localparam logic [26:0] K_SCALE   = 27'h3e80000;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      SWG_DC     = 2'b00,
      SWG_SINE   = 2'b01,
      SWG_SQUARE = 2'b10,
      SWG_TRI    = 2'b11
   } swg_shape_t;
   typedef struct packed {
      swg_shape_t         shape;
      logic [15:0]        amp;
      logic signed [15:0] offs;
      logic [16:0]        thr;
      logic [26:0]        k_up;
      logic [26:0]        k_dn;
      logic [31:0]        step;
   } swg_cfg_t;
endpackage
`default_nettype wire

// [verification/swg_dac_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// converter sink model
// ----------------------------------------
module swg_dac_model (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic [1:0]  i_mode,
   input  wire logic        i_valid,
   input  wire logic [15:0] i_data,
   output logic             o_ready,
   output logic [15:0]      o_last
);
   logic [7:0] lfsr_ff;
   // lfsr keeps the stall pattern repeatable; mode 0 never stalls, mode 2 always does
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         lfsr_ff <= 8'h5a;
      else
         lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
   end
   assign o_ready = (i_mode == 2'h0) | ((i_mode == 2'h1) & lfsr_ff[0]);
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_last <= 16'h0000;
      else if (i_valid && o_ready)
         o_last <= i_data;
   end
endmodule
`default_nettype wire

// [verification/source_waveform_generator_test.sv]
`timescale 1ns/1ps
`default_nettype none
module source_waveform_generator_test;
   // ----------------------------------------
   // stimulus and observation
   // ----------------------------------------
   int                 err_count = 0;
   int                 n_checks  = 0;
   int                 seed      = 8828;
   logic               clk       = 1'b0;
   logic               rst_n     = 1'b0;
   logic               cyc       = 1'b0;
   logic               stb       = 1'b0;
   logic               we        = 1'b0;
   logic [7:0]         adr       = 8'h00;
   logic [3:0]         sel       = 4'h0;
   logic [31:0]        wdat      = 32'h0000_0000;
   logic [1:0]         mode      = 2'h0;
   logic [31:0]        o_dat;
   logic [31:0]        rdat;
   logic               ack;
   logic               s_valid;
   logic               s_ready;
   logic               out_en;
   logic [15:0]        s_data;
   logic [15:0]        m_last;
   logic [15:0]        held;
   logic signed [15:0] sbuf [0:1023];
   logic signed [15:0] amp;
   logic signed [15:0] offs;
   logic signed [15:0] mn;
   logic signed [15:0] mx;
   int                 n_s = 0;
   int                 base;
   int                 nhi;
   int                 nlo;
   int                 nup;
   logic [7:0]         r_adr [0:5] = '{swg_pkg::A_CTRL, swg_pkg::A_AMP, swg_pkg::A_OFFS,
                                       swg_pkg::A_FREQ, swg_pkg::A_DUTY, 8'h1c};
   logic [31:0]        r_exp [0:5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1f4, 32'h0};
   int                 d_set [0:1];
   int                 d_exp [0:1];

   always #20 clk = ~clk;

   swg_top #(.FIFO_DEPTH(4)) swg_top_i (
      .I_CLK(clk), .I_RESET_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
      .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(o_dat), .O_WB_ACK(ack),
      .O_SAMPLE_DATA(s_data), .O_SAMPLE_VALID(s_valid), .I_SAMPLE_READY(s_ready),
      .O_OUT_EN(out_en));

   swg_dac_model swg_dac_model_i (
      .i_clk(clk), .i_reset_n(rst_n), .i_mode(mode), .i_valid(s_valid), .i_data(s_data),
      .o_ready(s_ready), .o_last(m_last));

   // every accepted sample is logged for later analysis
   always @(posedge clk)
   begin
      if (s_valid && s_ready)
      begin
         sbuf[n_s % 1024] <= s_data;
         n_s <= n_s + 1;
      end
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   function logic near(input logic signed [31:0] a, input logic signed [31:0] b,
                       input logic signed [31:0] tol);
      return (a - b <= tol) && (b - a <= tol);
   endfunction

   // classic single cycle; waits for ack without assuming its latency
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      rdat = o_dat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (k >= 20)
         err_count++;
   endtask

   // skip 80 samples so latency and a pending swap at a 64-sample wrap are past
   task run(input int n, input logic signed [15:0] hi, input logic signed [15:0] lo);
      int k;
      logic signed [15:0] v;
      logic signed [15:0] p;
      k = 0;
      base = n_s + 80;
      while (n_s < base + n && k < 20000)
      begin
         @(posedge clk);
         k++;
      end
      if (k >= 20000)
         err_count++;
      mn = 16'sh7fff;
      mx = 16'sh8000;
      nhi = 0;
      nlo = 0;
      nup = 0;
      p = sbuf[base % 1024];
      for (int i = 0; i < n; i++)
      begin
         v = sbuf[(base + i) % 1024];
         if (v < mn) mn = v;
         if (v > mx) mx = v;
         if (v == hi) nhi++;
         if (v == lo) nlo++;
         if (v > p) nup++;
         p = v;
      end
   endtask

   task test_done;
      $display("checks=%0d errors=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      #(40 * 60000);
      err_count++;
      test_done;
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         wb(1'b0, r_adr[i], 32'h0);
         check(rdat, r_exp[i]);
      end
      check(out_en, 1'b0);
      amp = 16'($random(seed)) & 16'sh3fff;
      wb(1'b1, swg_pkg::A_AMP, 32'(amp));
      wb(1'b1, swg_pkg::A_OFFS, 32'h0123);
      wb(1'b0, swg_pkg::A_OFFS, 32'h0);
      check(rdat, 32'h0);
      wb(1'b1, swg_pkg::A_CTRL, 32'h1);
      run(16, amp, amp);
      check(32'(nhi), 32'd16);
      check(out_en, 1'b1);
      wb(1'b1, swg_pkg::A_DUTY, 32'd2000);
      wb(1'b0, swg_pkg::A_DUTY, 32'h0);
      check(rdat, 32'(swg_pkg::DUTY_FULL));
      wb(1'b1, swg_pkg::A_CTRL, 32'h4);
      amp = (16'($random(seed)) & 16'sh1fff) | 16'sh0100;
      offs = (16'($random(seed)) & 16'sh0fff) - 16'sh0800;
      wb(1'b1, swg_pkg::A_AMP, 32'(amp));
      wb(1'b1, swg_pkg::A_OFFS, 32'(offs));
      wb(1'b1, swg_pkg::A_FREQ, 32'h0400_0000);
      wb(1'b1, swg_pkg::A_DUTY, 32'd250);
      wb(1'b1, swg_pkg::A_CTRL, 32'h5);
      run(128, offs + amp, offs - amp);
      check(32'(nhi + nlo), 32'd128);
      check(near(nhi, 32, 1), 1'b1);
      check(near(nup, 2, 0), 1'b1);
      d_set = '{0, 1000};
      d_exp = '{0, 128};
      for (int i = 0; i < 2; i++)
      begin
         wb(1'b1, swg_pkg::A_DUTY, 32'(d_set[i]));
         run(128, offs + amp, offs - amp);
         check(32'(nhi), 32'(d_exp[i]));
      end
      // smallest square duty: one high sample in each 64-sample period
      wb(1'b1, swg_pkg::A_DUTY, 32'd1);
      run(128, offs + amp, offs - amp);
      check(32'(nhi), 32'd2);
      check(32'(nlo), 32'd126);
      // triangle under random stalls from the sink
      mode <= 2'h1;
      d_set = '{750, 1000};
      d_exp = '{96, 126};
      wb(1'b1, swg_pkg::A_CTRL, 32'h7);
      for (int i = 0; i < 2; i++)
      begin
         wb(1'b1, swg_pkg::A_DUTY, 32'(d_set[i]));
         run(128, offs + amp, offs - amp);
         check(near(nup, d_exp[i], 3), 1'b1);
         check(near(mx, offs + amp, amp / 8 + 2), 1'b1);
         check(near(mn, offs - amp, amp / 8 + 2), 1'b1);
      end
      mode <= 2'h0;
      wb(1'b1, swg_pkg::A_AMP, 32'd1000);
      wb(1'b1, swg_pkg::A_CTRL, 32'hb);
      run(128, 16'sh0, 16'sh0);
      check(near(mx, offs + 1414, 8), 1'b1);
      check(near(mn, offs - 1414, 8), 1'b1);
      check(near(nup, 64, 3), 1'b1);
      // a stalled sink must fill the buffer and freeze the stream
      mode <= 2'h2;
      repeat (20) @(posedge clk);
      wb(1'b0, swg_pkg::A_STAT, 32'h0);
      check(rdat[2], 1'b1);
      held = s_data;
      repeat (5) @(posedge clk);
      check(s_data, held);
      wb(1'b0, swg_pkg::A_SAMP, 32'h0);
      check(rdat[15:0], held);
      mode <= 2'h0;
      wb(1'b1, swg_pkg::A_CTRL, 32'h0);
      repeat (2) @(posedge clk);
      check(out_en, 1'b0);
      run(16, 16'sh0, 16'sh0);
      check(32'(nhi), 32'd16);
      check(m_last, 16'h0);
      wb(1'b0, swg_pkg::A_OFFS, 32'h0);
      check(rdat, 32'h0);
      test_done;
   end
endmodule
`default_nettype wire
